// ---- common/tmr_params.svh ----
// constants of the 16-bit timer mode sequencer: mode codes, tops, actions
// assumes inclusion by its bare name from the package and the modules
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH
`define TMR_W 16
`define TMR_MAX 16'hFFFF
`define TMR_BOTTOM 16'h0000
`define TMR_TOP8 16'h00FF
`define TMR_TOP9 16'h01FF
`define TMR_TOP10 16'h03FF
`define TMR_WGM_NORMAL 4'h0
`define TMR_WGM_CTC_OCR 4'h4
`define TMR_WGM_PWM8 4'h5
`define TMR_WGM_PWM9 4'h6
`define TMR_WGM_PWM10 4'h7
`define TMR_WGM_CTC_ICR 4'hC
`define TMR_WGM_PWM_ICR 4'hE
`define TMR_WGM_PWM_OCR 4'hF
`define TMR_ACT_NONE 2'h0
`define TMR_ACT_TOGGLE 2'h1
`define TMR_ACT_CLEAR 2'h2
`define TMR_ACT_SET 2'h3
`define TMR_CS_STOP 3'h0
`define TMR_CS_DIV1 3'h1
`define TMR_CS_DIV8 3'h2
`define TMR_CS_DIV64 3'h3
`define TMR_CS_DIV256 3'h4
`define TMR_CS_DIV1024 3'h5
`define TMR_PRE_W 10
`define TMR_DIV8_MASK 10'h007
`define TMR_DIV64_MASK 10'h03F
`define TMR_DIV256_MASK 10'h0FF
`define TMR_DIV1024_MASK 10'h3FF
`endif

// ---- common/tmr_pkg.sv ----
// types of the 16-bit timer mode sequencer
// assumes tmr_params.svh on the include path
`include "tmr_params.svh"
package tmr_pkg;
   typedef logic [`TMR_W-1:0] tmr_word_t;
   typedef enum logic [2:0] {
      TMR_NORMAL, TMR_CTC_OCR, TMR_CTC_ICR, TMR_PWM8,
      TMR_PWM9, TMR_PWM10, TMR_PWM_ICR, TMR_PWM_OCR
   } tmr_mode_e;

   // phase-correct codes are not built; they fall back to plain counting
   function automatic tmr_mode_e tmr_decode(input logic [3:0] code);
      tmr_mode_e m;
      m = TMR_NORMAL;
      unique case (code)
         `TMR_WGM_NORMAL: m = TMR_NORMAL;
         `TMR_WGM_CTC_OCR: m = TMR_CTC_OCR;
         `TMR_WGM_CTC_ICR: m = TMR_CTC_ICR;
         `TMR_WGM_PWM8: m = TMR_PWM8;
         `TMR_WGM_PWM9: m = TMR_PWM9;
         `TMR_WGM_PWM10: m = TMR_PWM10;
         `TMR_WGM_PWM_ICR: m = TMR_PWM_ICR;
         `TMR_WGM_PWM_OCR: m = TMR_PWM_OCR;
         default: m = TMR_NORMAL;
      endcase
      return m;
   endfunction
endpackage

// ---- common/tmr_cmp_if.sv ----
// link between the sequencer and one compare/output channel
// assumes tmr_pkg compiled first
`timescale 1ns/1ps
interface tmr_cmp_if;
   import tmr_pkg::*;
   logic clk_en;
   logic tick;
   logic block;
   logic pwm;
   logic bottom;
   logic toggle_ok;
   logic flag_clr;
   logic sync_rst;
   tmr_word_t count;
   tmr_word_t value;
   logic [1:0] action;
   logic flag;
   logic wave;
   modport ctl(output clk_en, tick, block, pwm, bottom, toggle_ok,
      flag_clr, sync_rst, count, value, action, input flag, wave);
   modport unit(input clk_en, tick, block, pwm, bottom, toggle_ok,
      flag_clr, sync_rst, count, value, action, output flag, wave);
endinterface

// ---- rtl/tmr_prescale.sv ----
// timer clock prescaler: one-cycle tick at the selected division
// assumes clk_en freezes it together with the rest of the timer
`timescale 1ns/1ps
`include "tmr_params.svh"
module tmr_prescale
   import tmr_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_en,
   // control
   input wire logic [2:0] clock_select,
   // timer clock
   output logic tick
);
   logic [`TMR_PRE_W-1:0] div;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         div <= '0;
      end else if (clk_en) begin
         div <= div + 1'b1;
      end
   end

   // unsupported selects stop the timer
   always_comb begin
      unique case (clock_select)
         `TMR_CS_DIV1: tick = clk_en;
         `TMR_CS_DIV8: tick = clk_en && (div & `TMR_DIV8_MASK) ==
            `TMR_DIV8_MASK;
         `TMR_CS_DIV64: tick = clk_en && (div & `TMR_DIV64_MASK) ==
            `TMR_DIV64_MASK;
         `TMR_CS_DIV256: tick = clk_en && (div & `TMR_DIV256_MASK) ==
            `TMR_DIV256_MASK;
         `TMR_CS_DIV1024: tick = clk_en && div == `TMR_DIV1024_MASK;
         default: tick = 1'b0;
      endcase
   end
endmodule

// ---- rtl/tmr_compare.sv ----
// one compare channel: match, compare flag and internal waveform level
// assumes the sequencer supplies tick, block and bottom on clk_sys
`timescale 1ns/1ps
`include "tmr_params.svh"
module tmr_compare
   import tmr_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // sequencer side
   tmr_cmp_if.unit cmp
);
   logic hit;

   assign hit = cmp.tick && !cmp.block && cmp.count == cmp.value;

   // set beats a clear arriving in the same cycle
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cmp.flag <= 1'b0;
      end else if (cmp.clk_en) begin
         if (cmp.sync_rst) begin
            cmp.flag <= 1'b0;
         end else if (hit) begin
            cmp.flag <= 1'b1;
         end else if (cmp.flag_clr) begin
            cmp.flag <= 1'b0;
         end
      end
   end

   // action only shapes the level, never the count
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cmp.wave <= 1'b0;
      end else if (cmp.clk_en) begin
         if (cmp.sync_rst) begin
            cmp.wave <= 1'b0;
         end else if (cmp.pwm) begin
            unique case (cmp.action)
               `TMR_ACT_NONE: cmp.wave <= cmp.wave;
               `TMR_ACT_TOGGLE: cmp.wave <= cmp.wave ^ (hit && cmp.toggle_ok);
               // bottom wins so compare equal to top gives a flat level
               `TMR_ACT_CLEAR: cmp.wave <= cmp.bottom ? 1'b1 :
                  (hit ? 1'b0 : cmp.wave);
               `TMR_ACT_SET: cmp.wave <= cmp.bottom ? 1'b0 :
                  (hit ? 1'b1 : cmp.wave);
            endcase
         end else if (hit) begin
            unique case (cmp.action)
               `TMR_ACT_NONE: cmp.wave <= cmp.wave;
               `TMR_ACT_TOGGLE: cmp.wave <= !cmp.wave;
               `TMR_ACT_CLEAR: cmp.wave <= 1'b0;
               `TMR_ACT_SET: cmp.wave <= 1'b1;
            endcase
         end
      end
   end
endmodule

// ---- rtl/tmr_seq.sv ----
// 16-bit timer mode sequencer: counter, tops, buffers, flags and pins
// assumes all control ports come from logic on clk_sys, so none is synced
`timescale 1ns/1ps
`include "tmr_params.svh"
module tmr_seq
   import tmr_pkg::*;
(
   // clock, reset, freeze
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic sync_rst,
   // configuration, loaded by cfg_wr
   input wire logic cfg_wr,
   input wire logic [3:0] waveform_mode_select,
   input wire logic [1:0] output_action_select_a,
   input wire logic [1:0] output_action_select_b,
   input wire logic [2:0] clock_select,
   // data writes
   input wire logic [`TMR_W-1:0] wr_data,
   input wire logic counter_wr,
   input wire logic compare_a_wr,
   input wire logic compare_b_wr,
   input wire logic capture_wr,
   // flag clears
   input wire logic overflow_ack,
   input wire logic overflow_clr,
   input wire logic compare_a_clr,
   input wire logic compare_b_clr,
   input wire logic capture_clr,
   // pin direction
   input wire logic pin_direction_bit_a,
   input wire logic pin_direction_bit_b,
   // state
   output logic [`TMR_W-1:0] counter_value,
   output logic [`TMR_W-1:0] compare_a_value,
   output logic [`TMR_W-1:0] compare_b_value,
   output logic [`TMR_W-1:0] capture_value,
   output logic overflow_flag,
   output logic compare_a_flag,
   output logic compare_b_flag,
   output logic capture_flag,
   output logic wave_out_a,
   output logic wave_out_b,
   // pins
   output logic pin_a_out,
   output logic pin_a_oe,
   output logic pin_b_out,
   output logic pin_b_oe
);
   ////////////////////////////////////////////////////////////////////////
   logic [3:0] mode_code;
   logic [1:0] act_a;
   logic [1:0] act_b;
   logic [2:0] cs;
   tmr_mode_e mode;
   logic pwm;
   logic clear_on_match_mode;
   logic tick;
   logic block;
   logic top_hit;
   logic ovf_set;
   logic cap_set;
   tmr_word_t top;
   tmr_word_t buf_a;
   tmr_word_t buf_b;
   tmr_word_t wmask;
   tmr_cmp_if ch_a();
   tmr_cmp_if ch_b();

   ////////////////////////////////////////////////////////////////////////
   // configuration
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mode_code <= `TMR_WGM_NORMAL;
         act_a <= `TMR_ACT_NONE;
         act_b <= `TMR_ACT_NONE;
         cs <= `TMR_CS_STOP;
      end else if (clk_en) begin
         if (sync_rst) begin
            mode_code <= `TMR_WGM_NORMAL;
            act_a <= `TMR_ACT_NONE;
            act_b <= `TMR_ACT_NONE;
            cs <= `TMR_CS_STOP;
         end else if (cfg_wr) begin
            mode_code <= waveform_mode_select;
            act_a <= output_action_select_a;
            act_b <= output_action_select_b;
            cs <= clock_select;
         end
      end
   end

   assign mode = tmr_decode(mode_code);
   assign pwm = mode inside {TMR_PWM8, TMR_PWM9, TMR_PWM10,
      TMR_PWM_ICR, TMR_PWM_OCR};
   assign clear_on_match_mode = mode inside {TMR_CTC_OCR, TMR_CTC_ICR};

   tmr_prescale u_pre (
      .clk_sys(clk_sys),
      .rst(rst),
      .clk_en(clk_en),
      .clock_select(cs),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////
   // top selection; only the mode code picks it, never the action
   always_comb begin
      top = `TMR_MAX;
      unique case (mode)
         TMR_NORMAL: top = `TMR_MAX;
         TMR_CTC_OCR: top = compare_a_value;
         TMR_CTC_ICR: top = capture_value;
         TMR_PWM8: top = `TMR_TOP8;
         TMR_PWM9: top = `TMR_TOP9;
         TMR_PWM10: top = `TMR_TOP10;
         TMR_PWM_ICR: top = capture_value;
         TMR_PWM_OCR: top = compare_a_value;
      endcase
   end

   // fixed tops mask the unused compare bits on write
   always_comb begin
      unique case (mode)
         TMR_PWM8: wmask = `TMR_TOP8;
         TMR_PWM9: wmask = `TMR_TOP9;
         TMR_PWM10: wmask = `TMR_TOP10;
         default: wmask = `TMR_MAX;
      endcase
   end

   // a blocked tick cannot see top either
   assign top_hit = tick && !block && counter_value == top;
   assign ovf_set = tick && (pwm ? top_hit :
      counter_value == `TMR_MAX);
   assign cap_set = top_hit &&
      (mode == TMR_CTC_ICR || mode == TMR_PWM_ICR);

   ////////////////////////////////////////////////////////////////////////
   // counter
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         counter_value <= `TMR_BOTTOM;
      end else if (clk_en) begin
         if (sync_rst) begin
            counter_value <= `TMR_BOTTOM;
         end else if (counter_wr) begin
            counter_value <= wr_data;
         end else if (tick) begin
            // a missed top simply wraps through max
            if ((pwm || clear_on_match_mode) && top_hit) begin
               counter_value <= `TMR_BOTTOM;
            end else begin
               counter_value <= counter_value + 1'b1;
            end
         end
      end
   end

   // match blocking after a counter write, held even while stopped
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         block <= 1'b0;
      end else if (clk_en) begin
         if (sync_rst) begin
            block <= 1'b0;
         end else if (counter_wr) begin
            block <= 1'b1;
         end else if (tick) begin
            block <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // compare and capture registers; compare buffered only in pwm modes, capture never
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         compare_a_value <= `TMR_BOTTOM;
         compare_b_value <= `TMR_BOTTOM;
         buf_a <= `TMR_BOTTOM;
         buf_b <= `TMR_BOTTOM;
      end else if (clk_en) begin
         if (compare_a_wr) begin
            buf_a <= wr_data & wmask;
         end
         if (compare_b_wr) begin
            buf_b <= wr_data & wmask;
         end
         if (pwm) begin
            if (top_hit) begin
               compare_a_value <= buf_a;
               compare_b_value <= buf_b;
            end
         end else begin
            // unbuffered top takes effect at once
            if (compare_a_wr) begin
               compare_a_value <= wr_data;
            end
            if (compare_b_wr) begin
               compare_b_value <= wr_data;
            end
         end
      end
   end

   // capture unit itself is outside; software loads the top here
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         capture_value <= `TMR_BOTTOM;
      end else if (clk_en && capture_wr) begin
         capture_value <= wr_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flags: set wins over a clear strobe in the same cycle, but sync_rst wins over set
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         overflow_flag <= 1'b0;
      end else if (clk_en) begin
         if (sync_rst) begin
            overflow_flag <= 1'b0;
         end else if (ovf_set) begin
            overflow_flag <= 1'b1;
         end else if (overflow_ack || overflow_clr) begin
            overflow_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         capture_flag <= 1'b0;
      end else if (clk_en) begin
         if (sync_rst) begin
            capture_flag <= 1'b0;
         end else if (cap_set) begin
            capture_flag <= 1'b1;
         end else if (capture_clr) begin
            capture_flag <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // compare channels; compare A matching its own top sets its flag
   assign ch_a.clk_en = clk_en;
   assign ch_a.tick = tick;
   assign ch_a.block = block;
   assign ch_a.pwm = pwm;
   assign ch_a.bottom = pwm && top_hit;
   assign ch_a.toggle_ok = !pwm || mode == TMR_PWM_OCR;
   assign ch_a.flag_clr = compare_a_clr;
   assign ch_a.sync_rst = sync_rst;
   assign ch_a.count = counter_value;
   assign ch_a.value = compare_a_value;
   assign ch_a.action = act_a;

   // channel B cannot toggle in pwm modes
   assign ch_b.clk_en = clk_en;
   assign ch_b.tick = tick;
   assign ch_b.block = block;
   assign ch_b.pwm = pwm;
   assign ch_b.bottom = pwm && top_hit;
   assign ch_b.toggle_ok = !pwm;
   assign ch_b.flag_clr = compare_b_clr;
   assign ch_b.sync_rst = sync_rst;
   assign ch_b.count = counter_value;
   assign ch_b.value = compare_b_value;
   assign ch_b.action = act_b;

   tmr_compare u_cmp_a (
      .clk_sys(clk_sys),
      .rst(rst),
      .cmp(ch_a.unit)
   );

   tmr_compare u_cmp_b (
      .clk_sys(clk_sys),
      .rst(rst),
      .cmp(ch_b.unit)
   );

   assign compare_a_flag = ch_a.flag;
   assign compare_b_flag = ch_b.flag;
   assign wave_out_a = ch_a.wave;
   assign wave_out_b = ch_b.wave;

   ////////////////////////////////////////////////////////////////////////
   // pins: registered so the pad sees no decode glitch, one cycle behind
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pin_a_out <= 1'b0;
         pin_a_oe <= 1'b0;
         pin_b_out <= 1'b0;
         pin_b_oe <= 1'b0;
      end else if (clk_en) begin
         pin_a_out <= ch_a.wave && pin_direction_bit_a;
         pin_a_oe <= pin_direction_bit_a;
         pin_b_out <= ch_b.wave && pin_direction_bit_b;
         pin_b_oe <= pin_direction_bit_b;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   logic live;
   assign live = clk_en && !sync_rst;

   sequence s_wrap;
      live && tick && !counter_wr && mode == TMR_NORMAL &&
         counter_value == `TMR_MAX;
   endsequence

   sequence s_ctc_top;
      live && tick && !counter_wr && clear_on_match_mode && top_hit;
   endsequence

   property p_normal_wrap;
      s_wrap |=> counter_value == `TMR_BOTTOM;
   endproperty
   a_normal_wrap: assert property (p_normal_wrap)
      else $error("normal mode did not wrap to zero");

   property p_ovf_at_zero;
      s_wrap |=> overflow_flag && counter_value == `TMR_BOTTOM;
   endproperty
   a_ovf_at_zero: assert property (p_ovf_at_zero)
      else $error("overflow flag not set as counter became zero");

   property p_ovf_ack;
      live && overflow_ack && !ovf_set |=> !overflow_flag;
   endproperty
   a_ovf_ack: assert property (p_ovf_ack)
      else $error("overflow flag not cleared by interrupt");

   property p_cnt_write;
      live && counter_wr |=> counter_value == $past(wr_data) && block;
   endproperty
   a_cnt_write: assert property (p_cnt_write)
      else $error("counter write not taken");

   property p_ctc_clear;
      s_ctc_top |=> counter_value == `TMR_BOTTOM;
   endproperty
   a_ctc_clear: assert property (p_ctc_clear)
      else $error("clear-on-match did not clear after top");

   property p_ctc_cap_flag;
      s_ctc_top ##0 (mode == TMR_CTC_ICR) |=> capture_flag;
   endproperty
   a_ctc_cap_flag: assert property (p_ctc_cap_flag)
      else $error("capture flag not set at top");

   property p_match_flag;
      live && tick && !block && counter_value == compare_a_value
         |=> compare_a_flag;
   endproperty
   a_match_flag: assert property (p_match_flag)
      else $error("compare match did not set compare flag");

   property p_block;
      live && block && tick && !counter_wr && !compare_a_flag &&
         !ovf_set |=> !compare_a_flag && $stable(ch_a.wave);
   endproperty
   a_block: assert property (p_block)
      else $error("blocked tick still produced a match");

   property p_pwm_load;
      live && pwm && top_hit && !counter_wr |=>
         compare_a_value == $past(buf_a) &&
         counter_value == `TMR_BOTTOM && overflow_flag;
   endproperty
   a_pwm_load: assert property (p_pwm_load)
      else $error("pwm buffer not loaded at top");

   property p_pwm_bottom;
      live && pwm && top_hit && act_a == `TMR_ACT_CLEAR |=> wave_out_a;
   endproperty
   a_pwm_bottom: assert property (p_pwm_bottom)
      else $error("non-inverting output not set at bottom");

   property p_pin_gate;
      clk_en |=> pin_a_oe == $past(pin_direction_bit_a) &&
         (pin_a_out == ($past(wave_out_a) && $past(pin_direction_bit_a)));
   endproperty
   a_pin_gate: assert property (p_pin_gate)
      else $error("output pin not gated by its direction bit");

   property p_sync_rst;
      clk_en && sync_rst |=> counter_value == `TMR_BOTTOM &&
         !overflow_flag && !compare_a_flag && mode_code == `TMR_WGM_NORMAL;
   endproperty
   a_sync_rst: assert property (p_sync_rst)
      else $error("synchronous reset left state behind");
endmodule

// ---- dv/tmr_load.sv ----
// external load on waveform pin A: counts level changes it is driven with
// assumes pin_out and pin_oe come straight from the sequencer's pin ports
`timescale 1ns/1ps
module tmr_load (
   // clock and control
   input wire logic clk_sys,
   input wire logic clr,
   // pin
   input wire logic pin_out,
   input wire logic pin_oe,
   // observation
   output int toggles
);
   logic last = 1'b0;
   initial toggles = 0;
   // an undriven pin cannot move the load, so it is not counted
   always @(posedge clk_sys) begin
      if (clr) toggles <= 0;
      else if (pin_oe && pin_out !== last) toggles <= toggles + 1;
      last <= pin_out;
   end
endmodule

// ---- dv/tmr_seq_bench.sv ----
// bench for the timer mode sequencer: write, config and clear tasks
// assumes tmr_load on pin A and a 125 MHz clk_sys
`timescale 1ns/1ps
`include "tmr_params.svh"
module tmr_seq_bench
   import tmr_pkg::*;
;
   logic clk_sys = 0, rst = 1, sync_rst = 0, cfg_wr = 0, tclr = 0;
   logic [3:0] wmode = 0, wstb = 0;
   logic [1:0] act_a = 0, act_b = 0;
   logic [2:0] csel = 0;
   logic [4:0] cstb = 0;
   logic [15:0] wr_data = 0, v;
   logic dir_a = 0, dir_b = 0;
   wire logic [15:0] cnt, cmpa, cmpb, capv;
   wire logic ovf, fa, fb, fc, wa, wb, pa, pae, pb, pbe;
   int toggles, fails = 0, checks_done = 0;
   int dv[4] = '{8, 64, 256, 1024};
   logic [3:0] md[4] = '{4'h4, 4'hC, 4'hE, 4'hF};
   always #4 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////////////////
   tmr_seq tmr_seq_i (.clk_sys(clk_sys), .rst(rst), .clk_en(1'b1),
      .sync_rst(sync_rst), .cfg_wr(cfg_wr), .waveform_mode_select(wmode),
      .output_action_select_a(act_a), .output_action_select_b(act_b),
      .clock_select(csel), .wr_data(wr_data), .counter_wr(wstb[0]),
      .compare_a_wr(wstb[1]), .capture_wr(wstb[2]), .compare_b_wr(wstb[3]),
      .overflow_ack(cstb[0]), .overflow_clr(cstb[1]),
      .compare_a_clr(cstb[2]), .compare_b_clr(cstb[3]),
      .capture_clr(cstb[4]), .pin_direction_bit_a(dir_a),
      .pin_direction_bit_b(dir_b), .counter_value(cnt),
      .compare_a_value(cmpa), .compare_b_value(cmpb), .capture_value(capv),
      .overflow_flag(ovf), .compare_a_flag(fa), .compare_b_flag(fb),
      .capture_flag(fc), .wave_out_a(wa), .wave_out_b(wb), .pin_a_out(pa),
      .pin_a_oe(pae), .pin_b_out(pb), .pin_b_oe(pbe));
   tmr_load tmr_load_i (.clk_sys(clk_sys), .clr(tclr), .pin_out(pa),
      .pin_oe(pae), .toggles(toggles));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // strobes rise and fall on falling edges, one rising edge apart
   task automatic wr(input int k, input logic [15:0] d);
      @(negedge clk_sys);
      wr_data = d;
      wstb = 4'h1 << k;
      @(negedge clk_sys);
      wstb = 4'h0;
   endtask
   task automatic clr(input logic [4:0] m);
      @(negedge clk_sys);
      cstb = m;
      @(negedge clk_sys);
      cstb = 5'h00;
   endtask
   task automatic cfg(input logic [3:0] m, input logic [1:0] a,
      input logic [2:0] cs);
      @(negedge clk_sys);
      {wmode, act_a, act_b, csel} = {m, a, 2'h3, cs};
      cfg_wr = 1;
      @(negedge clk_sys);
      cfg_wr = 0;
   endtask
   task automatic give_verdict();
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5) @(negedge clk_sys);
      rst = 0;
      @(negedge clk_sys);
      chk(cnt, 16'h0000);
      cfg(`TMR_WGM_NORMAL, `TMR_ACT_NONE, `TMR_CS_DIV1);
      wr(0, 16'hFFFE);
      @(negedge clk_sys);
      chk(16'(ovf), 16'h0000);
      @(negedge clk_sys);
      chk(cnt, 16'h0000);
      chk(16'(ovf), 16'h0001);
      clr(5'h01);
      chk(16'(ovf), 16'h0000);
      // top of three: a count of 0,1,2,3 in every top-defined mode
      wr(1, 16'h0003);
      wr(2, 16'h0003);
      chk(capv, 16'h0003);
      for (int m = 0; m < 4; m++) begin
         cfg(md[m], `TMR_ACT_NONE, `TMR_CS_DIV1);
         wr(0, 16'h0000);
         for (int i = 1; i <= 8; i++) begin
            @(negedge clk_sys);
            chk(cnt, 16'(i % 4));
         end
      end
      chk(16'({fa, fc}), 16'h0003);
      cfg(`TMR_WGM_CTC_OCR, `TMR_ACT_TOGGLE, `TMR_CS_DIV1);
      repeat (4) @(negedge clk_sys);
      chk(16'({pae, pbe, pb, fb, wb}), 16'h0003);
      dir_a = 1;
      @(negedge clk_sys);
      tclr = 1;
      @(negedge clk_sys);
      tclr = 0;
      repeat (32) @(negedge clk_sys);
      chk(16'(toggles), 16'h0008);
      wr(0, 16'h0003);
      @(negedge clk_sys);
      chk(cnt, 16'h0004);
      clr(5'h02);
      chk(16'(ovf), 16'h0000);
      wr(0, 16'hFFFF);
      @(negedge clk_sys);
      chk(16'(ovf), 16'h0001);
      wr(0, 16'h0014);
      wr(1, 16'h0005);
      chk(cmpa, 16'h0005);
      chk(cnt, 16'h0016);
      // fixed top 0xFF, non-inverted output, buffered compare
      cfg(`TMR_WGM_PWM8, `TMR_ACT_CLEAR, `TMR_CS_DIV1);
      wr(1, 16'h000A);
      chk(cmpa, 16'h0005);
      clr(5'h06);
      wr(0, 16'h00FE);
      repeat (2) @(negedge clk_sys);
      chk(cnt, 16'h0000);
      chk(cmpa, 16'h000A);
      chk(16'({ovf, wa}), 16'h0003);
      repeat (10) @(negedge clk_sys);
      chk(16'({fa, wa}), 16'h0001);
      @(negedge clk_sys);
      chk(16'({fa, wa}), 16'h0002);
      wr(3, 16'h0123);
      chk(cmpb, 16'h0000);
      for (int k = 0; k < 4; k++) begin
         cfg(`TMR_WGM_NORMAL, `TMR_ACT_NONE, 3'(`TMR_CS_DIV8 + k));
         v = cnt;
         repeat (2 * dv[k]) @(negedge clk_sys);
         chk(cnt, v + 16'h0002);
      end
      wr(3, 16'h0123);
      chk(cmpb, 16'h0123);
      sync_rst = 1;
      @(negedge clk_sys);
      sync_rst = 0;
      chk(16'({ovf, fa, fb, fc, wa, wb}), 16'h0000);
      @(negedge clk_sys);
      chk(cnt, 16'h0000);
      give_verdict();
   end
endmodule
